// [bench/zcb_gpr_model.sv]
`timescale 1ns/1ps
`default_nettype none
module zcb_gpr_model (
  input  wire logic        sys_clk_in, // core clock
  input  wire logic        we_in,      // load strobe
  input  wire logic [4:0]  wr_idx_in,  // load index
  input  wire logic [31:0] wr_val_in,  // load value
  input  wire logic [4:0]  rd_idx_in,  // source field
  output logic      [31:0] rd_out      // source value
);
  logic [31:0] gpr [32];
  always_ff @(posedge sys_clk_in) if (we_in) gpr[wr_idx_in] <= wr_val_in;
  // register zero is hardwired, so the slot word reads a clean zero
  assign rd_out = (rd_idx_in == 5'h00) ? 32'h0 : gpr[rd_idx_in];
endmodule
`default_nettype wire

// [bench/zcb_unit_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module zcb_unit_assertions (
  input wire logic                sys_clk_in,    // clock
  input wire logic                rst_in,        // reset
  input wire zcb_pkg::zcb_issue_t issue_in,      // issue
  input wire logic                hit_out,       // hit
  input wire logic                redirect_out,  // redirect
  input wire logic [31:0]         target_out,    // target
  input wire logic                nullify_out,   // squash
  input wire logic                link_we_out,   // link strobe
  input wire logic [4:0]          link_reg_out,  // link index
  input wire logic [31:0]         link_data_out  // link value
);
  logic [31:0] calc_r;
  logic [31:0] hold_r;
  // target_out only moves on redirect, so the branch's own target is carried here until then
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      calc_r <= 32'h0000_0000;
      hold_r <= 32'h0000_0000;
    end else begin
      calc_r <= issue_in.pc + 32'h0000_0004
              + {{14{issue_in.word[15]}}, issue_in.word[15:0], 2'b00};
      if (hit_out) hold_r <= calc_r;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_link_dest: assert property (link_we_out |-> link_reg_out == 5'h1F)
    else $error("link dest wrong");
  a_link_addr: assert property (link_we_out |-> link_data_out == $past(issue_in.pc) + 32'h8)
    else $error("link addr wrong");
  a_nullify_hit: assert property (nullify_out |-> hit_out)
    else $error("stray nullify");
  a_target_sum: assert property (redirect_out |-> target_out == hold_r)
    else $error("bad target");
  a_hit_valid: assert property (hit_out |-> $past(issue_in.valid))
    else $error("hit without issue");
  a_hit_opcode: assert property (hit_out |-> $past(issue_in.word[31:26]) inside
    {6'h01, 6'h07, 6'h17, 6'h06}) else $error("hit on foreign opcode");
  a_redirect_gap: assert property (redirect_out |=> !redirect_out)
    else $error("redirect twice");
  a_link_group: assert property (link_we_out |-> $past(issue_in.word[31:26]) == 6'h01
    && $past(issue_in.word[20])) else $error("link on non-link form");
  c_redirect: cover property (redirect_out);
  c_nullify: cover property (nullify_out);
  c_link: cover property (link_we_out);
endmodule
bind zcb_unit zcb_unit_assertions i_zcb_unit_assertions (.sys_clk_in, .rst_in, .issue_in,
  .hit_out, .redirect_out, .target_out, .nullify_out, .link_we_out, .link_reg_out,
  .link_data_out);
`default_nettype wire

// [bench/zcb_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module zcb_unit_bench;
  logic                clk, rst, v, we, hit, redir, nul, lwe;
  logic [31:0]         pc, word, val, src, target, ldata;
  logic [4:0]          rs, lreg;
  int                  failures, n_compared;
  zcb_pkg::zcb_issue_t issue;
  // {opcode, subcode}; the last entry carries a nonzero subcode and must be ignored
  logic [10:0] enc [8] = '{11'h021, 11'h031, 11'h033, 11'h023, 11'h0E0, 11'h2E0, 11'h0C0, 11'h0E1};
  assign issue = '{v, pc, word, src};
  zcb_unit i_zcb_unit (.sys_clk_in(clk), .rst_in(rst), .issue_in(issue), .hit_out(hit),
    .redirect_out(redir), .target_out(target), .nullify_out(nul), .link_we_out(lwe),
    .link_reg_out(lreg), .link_data_out(ldata));
  zcb_gpr_model i_zcb_gpr_model (.sys_clk_in(clk), .we_in(we), .wr_idx_in(rs),
    .wr_val_in(val), .rd_idx_in(word[25:21]), .rd_out(src));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    int          k;
    logic [1:0]  sel;
    logic [15:0] ofs;
    logic [31:0] p, tgt;
    logic        t, h, lk, ln;
    failures = 0;
    n_compared = 0;
    rst = 1;
    v = 0;
    we = 0;
    pc = 0;
    word = 0;
    val = 0;
    rs = 0;
    k = $urandom(32'h9E1F);
    repeat (3) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 400; i++) begin
      k = $urandom % 8;
      sel = 2'($urandom);
      ofs = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : 16'($urandom);
      p = $urandom & 32'hFFFF_FFFC;
      t = (k < 4) ? !val[31] : 1'b0;
      @(posedge clk);
      val <= sel[1] ? (sel[0] ? $urandom : 32'h8000_0000) : {31'h0, sel[0]};
      rs <= 5'(1 + $urandom % 30);
      we <= 1;
      v <= 0;
      @(posedge clk);
      we <= 0;
      v <= 1;
      pc <= p;
      word <= {enc[k][10:5], rs, enc[k][4:0], ofs};
      t = (k < 4) ? !val[31] : (k < 6) ? (!val[31] && val != 0) : (k == 6) && (val[31] || val == 0);
      h = (k != 7);
      lk = (k == 2 || k == 3 || k == 5);
      ln = (k == 1 || k == 2);
      tgt = p + 32'h4 + {{14{ofs[15]}}, ofs, 2'b00};
      @(posedge clk);
      pc <= p + 32'h4;
      word <= 32'h0;
      #1 chk("flags", 32'({hit, nul, lwe, redir}), 32'({h, h & lk & !t, ln, 1'b0}));
      if (ln) chk("link_data", ldata, p + 32'h8);
      if (ln) chk("link_reg", 32'(lreg), 32'h1F);
      @(posedge clk);
      v <= 0;
      #1 chk("redirect", 32'(redir), 32'(h & t));
      if (h & t) chk("target", target, tgt);
    end
    stop_test();
  end
endmodule
`default_nettype wire

// [verilog/zcb_consts.svh]
`ifndef ZCB_CONSTS_SVH
`define ZCB_CONSTS_SVH
`define ZCB_OPC_HI        31
`define ZCB_OPC_LO        26
`define ZCB_RS_HI         25
`define ZCB_RS_LO         21
`define ZCB_RT_HI         20
`define ZCB_RT_LO         16
`define ZCB_OFS_HI        15
`define ZCB_OFS_LO        0
`define ZCB_OP_REGISTER_IMMEDIATE_GROUP     6'h01
`define ZCB_OP_POS        6'h07
`define ZCB_OP_POS_L      6'h17
`define ZCB_OP_NONPOS     6'h06
`define ZCB_SUB_NONNEG    5'h01
`define ZCB_SUB_NONNEG_L  5'h03
`define ZCB_SUB_NONNEG_AL 5'h11
`define ZCB_SUB_NONNEG_ALL 5'h13
`define ZCB_SUB_ZERO      5'h00
`define ZCB_LINK_REG      5'h1F
`define ZCB_SLOT_STEP     32'h0000_0004
`define ZCB_LINK_STEP     32'h0000_0008
`define ZCB_SIGN_BIT      31
`endif

// [verilog/zcb_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "zcb_consts.svh"
module zcb_decode (
  input  wire logic [31:0]       word_in,  // instruction word
  output zcb_pkg::zcb_fields_t   fields_out, // split fields
  output zcb_pkg::zcb_op_t       op_out    // decoded variant
);
  always_comb begin
    fields_out.opcode  = word_in[`ZCB_OPC_HI:`ZCB_OPC_LO];
    fields_out.src_reg = word_in[`ZCB_RS_HI:`ZCB_RS_LO];
    fields_out.sub     = word_in[`ZCB_RT_HI:`ZCB_RT_LO];
    fields_out.offset  = word_in[`ZCB_OFS_HI:`ZCB_OFS_LO];
  end

  always_comb begin
    op_out = zcb_pkg::ZCB_NONE;
    case (fields_out.opcode)
      `ZCB_OP_REGISTER_IMMEDIATE_GROUP: begin
        case (fields_out.sub)
          `ZCB_SUB_NONNEG:     op_out = zcb_pkg::ZCB_NONNEG;
          `ZCB_SUB_NONNEG_AL:  op_out = zcb_pkg::ZCB_NONNEG_LINK;
          `ZCB_SUB_NONNEG_L:   op_out = zcb_pkg::ZCB_NONNEG_LIKELY;
          `ZCB_SUB_NONNEG_ALL: op_out = zcb_pkg::ZCB_NONNEG_LINK_LIKELY;
          default:             op_out = zcb_pkg::ZCB_NONE;
        endcase
      end
      // a nonzero sub field leaves these unrecognised rather than guessing
      `ZCB_OP_POS: begin
        if (fields_out.sub == `ZCB_SUB_ZERO) op_out = zcb_pkg::ZCB_POSITIVE;
      end
      `ZCB_OP_POS_L: begin
        if (fields_out.sub == `ZCB_SUB_ZERO) op_out = zcb_pkg::ZCB_POSITIVE_LIKELY;
      end
      `ZCB_OP_NONPOS: begin
        if (fields_out.sub == `ZCB_SUB_ZERO) op_out = zcb_pkg::ZCB_NONPOSITIVE;
      end
      default: op_out = zcb_pkg::ZCB_NONE;
    endcase
  end
endmodule
`default_nettype wire

// [verilog/zcb_pkg.sv]
`default_nettype none
package zcb_pkg;
  typedef enum logic [2:0] {
    ZCB_NONE,
    ZCB_NONNEG,
    ZCB_NONNEG_LINK,
    ZCB_NONNEG_LINK_LIKELY,
    ZCB_NONNEG_LIKELY,
    ZCB_POSITIVE,
    ZCB_POSITIVE_LIKELY,
    ZCB_NONPOSITIVE
  } zcb_op_t;

  typedef struct packed {
    logic [5:0]  opcode;
    logic [4:0]  src_reg;
    logic [4:0]  sub;
    logic [15:0] offset;
  } zcb_fields_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] word;
    logic [31:0] src_val;
  } zcb_issue_t;
endpackage
`default_nettype wire

// [verilog/zcb_unit.sv]
// Operation
// - split word into opcode, source, subcode, offset
// - recognise positive, positive-likely, nonpositive opcodes
// - register-immediate subcodes select link and likely
// - target is delay-slot address plus offset times four
// - redirect only after the delay slot executes
// - nonnegative forms take when sign bit clear
// - positive forms need sign clear and nonzero
// - nonpositive takes when negative or zero
// - link forms always write register 31
// - return address is branch address plus eight
// - likely forms nullify slot when not taken
`timescale 1ns/1ps
`default_nettype none
`include "zcb_consts.svh"
module zcb_unit (
  input  wire logic               sys_clk_in,      // core clock, 20 MHz
  input  wire logic               rst_in,          // async reset, active high
  input  wire zcb_pkg::zcb_issue_t issue_in,       // instruction in execute
  output logic                    hit_out,         // branch of this group executed
  output logic                    redirect_out,    // one-cycle pc redirect pulse
  output logic [31:0]             target_out,      // redirect address
  output logic                    nullify_out,     // squash the slot instruction
  output logic                    link_we_out,     // write return address
  output logic [4:0]              link_reg_out,    // link destination register
  output logic [31:0]             link_data_out    // return address
);
  zcb_pkg::zcb_fields_t fields;
  zcb_pkg::zcb_op_t     op;
  logic                 cond;
  logic                 is_link;
  logic                 is_likely;
  logic [31:0]          ofs_ext;
  logic [31:0]          tgt_nxt;
  logic                 pend_r;
  logic [31:0]          pend_tgt_r;

  zcb_decode u_dec (
    .word_in    (issue_in.word),
    .fields_out (fields),
    .op_out     (op)
  );

  function automatic logic link_form(input zcb_pkg::zcb_op_t o);
    link_form = (o == zcb_pkg::ZCB_NONNEG_LINK) || (o == zcb_pkg::ZCB_NONNEG_LINK_LIKELY);
  endfunction

  function automatic logic likely_form(input zcb_pkg::zcb_op_t o);
    likely_form = (o == zcb_pkg::ZCB_NONNEG_LINK_LIKELY) || (o == zcb_pkg::ZCB_NONNEG_LIKELY)
               || (o == zcb_pkg::ZCB_POSITIVE_LIKELY);
  endfunction

  always_comb begin
    is_link   = link_form(op);
    is_likely = likely_form(op);
    ofs_ext   = {{14{fields.offset[15]}}, fields.offset, 2'b00};
    tgt_nxt   = issue_in.pc + `ZCB_SLOT_STEP + ofs_ext;
    case (op)
      zcb_pkg::ZCB_NONNEG,
      zcb_pkg::ZCB_NONNEG_LINK,
      zcb_pkg::ZCB_NONNEG_LINK_LIKELY,
      zcb_pkg::ZCB_NONNEG_LIKELY:
        cond = ~issue_in.src_val[`ZCB_SIGN_BIT];
      zcb_pkg::ZCB_POSITIVE,
      zcb_pkg::ZCB_POSITIVE_LIKELY:
        cond = ~issue_in.src_val[`ZCB_SIGN_BIT] && (issue_in.src_val != 32'h0000_0000);
      zcb_pkg::ZCB_NONPOSITIVE:
        cond = issue_in.src_val[`ZCB_SIGN_BIT] || (issue_in.src_val == 32'h0000_0000);
      default:
        cond = 1'b0;
    endcase
  end

  // a taken branch is held one slot so the delay slot runs first
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r     <= 1'b0;
      pend_tgt_r <= 32'h0000_0000;
    end else if (pend_r) begin
      // the slot instruction is consumed by this cycle, whatever it was
      if (issue_in.valid) pend_r <= 1'b0;
    end else if (issue_in.valid && cond) begin
      pend_r     <= 1'b1;
      pend_tgt_r <= tgt_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      redirect_out <= 1'b0;
      target_out   <= 32'h0000_0000;
    end else begin
      // branches in a delay slot are not honoured: the pending one wins
      redirect_out <= pend_r && issue_in.valid;
      if (pend_r && issue_in.valid) target_out <= pend_tgt_r;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hit_out     <= 1'b0;
      nullify_out <= 1'b0;
    end else begin
      hit_out     <= issue_in.valid && !pend_r && (op != zcb_pkg::ZCB_NONE);
      // squash request lands as the slot instruction enters execute
      nullify_out <= issue_in.valid && !pend_r && is_likely && !cond;
    end
  end

  // register 31 as source is undefined by contract; no interlock is spent on it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_we_out   <= 1'b0;
      link_reg_out  <= 5'h00;
      link_data_out <= 32'h0000_0000;
    end else begin
      link_we_out <= issue_in.valid && !pend_r && is_link;
      if (issue_in.valid && !pend_r && is_link) begin
        link_reg_out  <= `ZCB_LINK_REG;
        link_data_out <= issue_in.pc + `ZCB_LINK_STEP;
      end
    end
  end
endmodule
`default_nettype wire
